// file: logic/pcps_params.svh
// offsets, field positions, reset values and timing counts of the pll control block
`ifndef PCPS_PARAMS_SVH
`define PCPS_PARAMS_SVH
`define PCPS_ADDR_CTRL 8'h00
`define PCPS_ADDR_PHASE 8'h04
`define PCPS_ADDR_FBDIV 8'h08
`define PCPS_ADDR_OUTDIV 8'h0C
`define PCPS_ADDR_OUTDIV4 8'h10
`define PCPS_ADDR_ROUTE 8'h14
`define PCPS_ADDR_STATUS 8'h18
`define PCPS_RST_CTRL 32'h0000_0000
`define PCPS_RST_PHASE 32'h0000_0000
`define PCPS_RST_FBDIV 32'h0101_0101
`define PCPS_RST_OUTDIV 32'h0101_0101
`define PCPS_RST_OUTDIV4 32'h0000_0001
`define PCPS_RST_ROUTE 32'h0000_000F
`define PCPS_ST_LOCK 0
`define PCPS_ST_CFG_ERR 1
`define PCPS_ST_HELD 2
`define PCPS_ST_OSC_RUN 3
`define PCPS_ST_PRODUCT 8
`define PCPS_PRODUCT_MAX 24'h0000FF
`define PCPS_CLK_PERIOD_PS 25000
`define PCPS_RST_MIN_NS 10
`define PCPS_RST_MIN_CYC ((`PCPS_RST_MIN_NS * 1000 + `PCPS_CLK_PERIOD_PS - 1) / `PCPS_CLK_PERIOD_PS)
`define PCPS_LOCK_EDGES 5'h10
`define PCPS_LOSS_CYC 8'h40
`define PCPS_OSC_HALF_10 4'h8
`define PCPS_OSC_HALF_20 4'h4
`define PCPS_OSC_HALF_40 4'h2
`define PCPS_OSC_HALF_80 4'h1
`endif

// file: logic/pcps_pkg.sv
// types of the pll control block
package pcps_pkg;
    typedef enum logic [1:0] {LK_RESET, LK_ACQUIRE, LK_LOCK_INDICATOR} pcps_lock_t;
    typedef struct packed {
        logic [19:0] pad;
        logic [4:0] invert;
        logic [1:0] osc_freq;
        logic osc_enable;
        logic fb_pin_mode;
        logic [1:0] ref_clock_select;
        logic pll_reset_low;
    } pcps_ctrl_t;
    typedef struct packed {
        logic [22:0] pad;
        logic phase_apply_strobe;
        logic [4:0] output_pick;
        logic [2:0] phase_value;
    } pcps_phase_t;
    typedef struct packed {
        logic [7:0] n;
        logic [7:0] feedback_divider;
        logic [7:0] o;
        logic [7:0] m;
    } pcps_fbdiv_t;
    typedef struct packed {
        logic [25:0] pad;
        logic regional_bottom;
        logic regional_top;
        logic [3:0] global_en;
    } pcps_route_t;
endpackage

// file: logic/pcps_out_div.sv
// one pll output: divider, one-clock-cycle-step phase delay line and polarity
`timescale 1ns/1ps
module pcps_out_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] div,
    input wire logic [2:0] phase,
    input wire logic apply,
    input wire logic invert,
    output logic clk_out
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic level;
    logic next_level;
    logic [7:0] dline;
    logic [7:0] next_dline;
    logic [2:0] phase_cur;
    logic [2:0] next_phase_cur;
    logic next_clk_out;
    logic [7:0] half;

    always_comb begin
        half = (div == 8'h00) ? 8'h01 : div;
        next_cnt = cnt;
        next_level = level;
        next_phase_cur = apply ? phase : phase_cur;
        if (!run) begin
            next_cnt = 8'h00;
            next_level = 1'b0;
        end else if (cnt >= half - 8'h01) begin
            next_cnt = 8'h00;
            next_level = ~level;
        end else begin
            next_cnt = cnt + 8'h01;
        end
        // each stage is one clk cycle
        next_dline = {dline[6:0], level};
        // default leaf polarity is inverted; option restores it
        next_clk_out = ~(dline[phase_cur] ^ invert);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            level <= 1'b0;
            dline <= 8'h00;
            phase_cur <= 3'h0;
            clk_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level <= next_level;
            dline <= next_dline;
            phase_cur <= next_phase_cur;
            clk_out <= next_clk_out;
        end
    end
endmodule

// file: logic/pcps_top.sv
// pll control with phase shift, reference select, lock and oscillator
`timescale 1ns/1ps
`include "pcps_params.svh"
module pcps_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] ref_clock_inputs,
    input wire logic core_feedback_input,
    input wire logic pin_feedback_input,
    output logic lock_indicator,
    output logic [3:0] global_clock_net,
    output logic pll_output_four_top,
    output logic pll_output_four_bottom,
    output logic osc_core_clock
);
    logic rst_m, rst_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // register index decode, 7 means unmapped
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            `PCPS_ADDR_CTRL: reg_index = 3'h0;
            `PCPS_ADDR_PHASE: reg_index = 3'h1;
            `PCPS_ADDR_FBDIV: reg_index = 3'h2;
            `PCPS_ADDR_OUTDIV: reg_index = 3'h3;
            `PCPS_ADDR_OUTDIV4: reg_index = 3'h4;
            `PCPS_ADDR_ROUTE: reg_index = 3'h5;
            `PCPS_ADDR_STATUS: reg_index = 3'h6;
            default: reg_index = 3'h7;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                o[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        merge = o;
    endfunction

    // pin inputs: three flops, change accepted when stages two and three agree
    logic [5:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_f, next_pin_f, pin_rise;

    assign pin_raw = {pin_feedback_input, core_feedback_input, ref_clock_inputs};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_pin
            always_comb begin
                next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
                pin_rise[gi] = next_pin_f[gi] & ~pin_f[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_s3 <= 6'h00;
            pin_f <= 6'h00;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= next_pin_f;
        end
    end

    // register file and bus slave
    pcps_pkg::pcps_ctrl_t ctrl, next_ctrl;
    pcps_pkg::pcps_phase_t phase, next_phase;
    pcps_pkg::pcps_fbdiv_t fbdiv, next_fbdiv;
    pcps_pkg::pcps_route_t route, next_route;
    logic [31:0] outdiv, next_outdiv, outdiv4, next_outdiv4, w_data, next_w_data, next_rdata, status;
    logic aw_got, next_aw_got, w_got, next_w_got, next_bvalid, next_rvalid;
    logic [7:0] aw_addr, next_aw_addr;
    logic [3:0] w_strb, next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic [2:0] widx;

    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always_comb begin
        next_ctrl = ctrl;
        next_phase = phase;
        next_fbdiv = fbdiv;
        next_outdiv = outdiv;
        next_outdiv4 = outdiv4;
        next_route = route;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        widx = reg_index(aw_addr);
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_got && w_got) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'h0;
            case (widx)
                3'h0: next_ctrl = merge(ctrl, w_data, w_strb);
                3'h1: next_phase = merge(phase, w_data, w_strb);
                3'h2: next_fbdiv = merge(fbdiv, w_data, w_strb);
                3'h3: next_outdiv = merge(outdiv, w_data, w_strb);
                3'h4: next_outdiv4 = merge(outdiv4, w_data, w_strb);
                3'h5: next_route = merge(route, w_data, w_strb);
                3'h6: next_bresp = 2'h0;
                default: next_bresp = 2'h2;
            endcase
            next_ctrl.pad = 20'h00000;
            next_phase.pad = 23'h000000;
            next_outdiv4[31:8] = 24'h000000;
            next_route.pad = 26'h0000000;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = 2'h0;
            case (reg_index(s_axi_araddr))
                3'h0: next_rdata = ctrl;
                3'h1: next_rdata = phase;
                3'h2: next_rdata = fbdiv;
                3'h3: next_rdata = outdiv;
                3'h4: next_rdata = outdiv4;
                3'h5: next_rdata = route;
                3'h6: next_rdata = status;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            ctrl <= `PCPS_RST_CTRL;
            phase <= `PCPS_RST_PHASE;
            fbdiv <= `PCPS_RST_FBDIV;
            outdiv <= `PCPS_RST_OUTDIV;
            outdiv4 <= `PCPS_RST_OUTDIV4;
            route <= `PCPS_RST_ROUTE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            ctrl <= next_ctrl;
            phase <= next_phase;
            fbdiv <= next_fbdiv;
            outdiv <= next_outdiv;
            outdiv4 <= next_outdiv4;
            route <= next_route;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // pll core model: reset stretch, reference latch, lock tracking
    logic [3:0] hold_cnt, next_hold_cnt;
    logic [1:0] active_sel, next_active_sel;
    pcps_pkg::pcps_lock_t lk_state, next_lk_state;
    logic [4:0] edge_cnt, next_edge_cnt;
    logic [7:0] ref_idle, next_ref_idle, fb_idle, next_fb_idle;
    logic [23:0] product;
    logic held, next_lock, cfg_err, ref_rise, fb_rise;

    assign held = ~ctrl.pll_reset_low | (hold_cnt != 4'h0);
    assign product = 24'(fbdiv.m * fbdiv.o * fbdiv.feedback_divider);
    assign cfg_err = (product > `PCPS_PRODUCT_MAX) | (fbdiv.n == 8'h00) | (product == 24'h0);
    assign ref_rise = pin_rise[active_sel];
    assign fb_rise = ctrl.fb_pin_mode ? pin_rise[5] : pin_rise[4];

    always_comb begin
        next_hold_cnt = hold_cnt;
        if (!ctrl.pll_reset_low) begin
            next_hold_cnt = 4'(`PCPS_RST_MIN_CYC);
        end else if (hold_cnt != 4'h0) begin
            next_hold_cnt = hold_cnt - 4'h1;
        end
        next_active_sel = held ? ctrl.ref_clock_select : active_sel;
        next_lk_state = lk_state;
        next_edge_cnt = edge_cnt;
        next_ref_idle = ref_rise ? 8'h00 : ref_idle + 8'h01;
        next_fb_idle = fb_rise ? 8'h00 : fb_idle + 8'h01;
        case (lk_state)
            pcps_pkg::LK_RESET: begin
                next_edge_cnt = 5'h00;
                next_ref_idle = 8'h00;
                next_fb_idle = 8'h00;
                if (!held && !cfg_err) begin
                    next_lk_state = pcps_pkg::LK_ACQUIRE;
                end
            end
            pcps_pkg::LK_ACQUIRE: begin
                if (ref_rise && fb_rise) begin
                    next_edge_cnt = edge_cnt + 5'h01;
                end
                if (edge_cnt >= `PCPS_LOCK_EDGES) begin
                    next_lk_state = pcps_pkg::LK_LOCK_INDICATOR;
                end
            end
            pcps_pkg::LK_LOCK_INDICATOR: begin
                if (ref_idle >= `PCPS_LOSS_CYC || fb_idle >= `PCPS_LOSS_CYC) begin
                    next_lk_state = pcps_pkg::LK_ACQUIRE;
                    next_edge_cnt = 5'h00;
                end
            end
            default: next_lk_state = pcps_pkg::LK_RESET;
        endcase
        if (ref_idle >= `PCPS_LOSS_CYC) begin
            next_ref_idle = `PCPS_LOSS_CYC;
        end
        if (fb_idle >= `PCPS_LOSS_CYC) begin
            next_fb_idle = `PCPS_LOSS_CYC;
        end
        if (held || cfg_err) begin
            next_lk_state = pcps_pkg::LK_RESET;
        end
        next_lock = (next_lk_state == pcps_pkg::LK_LOCK_INDICATOR);
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            hold_cnt <= 4'h0;
            active_sel <= 2'h0;
            lk_state <= pcps_pkg::LK_RESET;
            edge_cnt <= 5'h00;
            ref_idle <= 8'h00;
            fb_idle <= 8'h00;
            lock_indicator <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            active_sel <= next_active_sel;
            lk_state <= next_lk_state;
            edge_cnt <= next_edge_cnt;
            ref_idle <= next_ref_idle;
            fb_idle <= next_fb_idle;
            lock_indicator <= next_lock;
        end
    end

    // five outputs with phase shift and routing
    logic [4:0] out_clk;
    logic [3:0] next_global;
    logic next_top, next_bottom;
    logic [39:0] out_divs;

    // all five divider bytes in one vector, output four on top
    assign out_divs = {outdiv4[7:0], outdiv};

    generate
        for (gi = 0; gi < 5; gi++) begin : g_out
            pcps_out_div u_div (
                .clk(clk),
                .rst_n(rst_s),
                .run(lock_indicator),
                .div(out_divs[gi*8 +: 8]),
                .phase(phase.phase_value),
                .apply(phase.phase_apply_strobe & phase.output_pick[gi]),
                .invert(ctrl.invert[gi]),
                .clk_out(out_clk[gi])
            );
        end
    endgenerate

    always_comb begin
        next_global = out_clk[3:0] & route.global_en;
        next_top = out_clk[4] & route.regional_top;
        next_bottom = out_clk[4] & route.regional_bottom;
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            global_clock_net <= 4'h0;
            pll_output_four_top <= 1'b0;
            pll_output_four_bottom <= 1'b0;
        end else begin
            global_clock_net <= next_global;
            pll_output_four_top <= next_top;
            pll_output_four_bottom <= next_bottom;
        end
    end

    // low-power oscillator model
    logic [3:0] osc_cnt, next_osc_cnt, osc_half;
    logic next_osc;

    always_comb begin
        case (ctrl.osc_freq)
            2'h0: osc_half = `PCPS_OSC_HALF_10;
            2'h1: osc_half = `PCPS_OSC_HALF_20;
            2'h2: osc_half = `PCPS_OSC_HALF_40;
            default: osc_half = `PCPS_OSC_HALF_80;
        endcase
        next_osc_cnt = osc_cnt + 4'h1;
        next_osc = osc_core_clock;
        if (!ctrl.osc_enable) begin
            next_osc_cnt = 4'h0;
            next_osc = 1'b0;
        end else if (osc_cnt >= osc_half - 4'h1) begin
            next_osc_cnt = 4'h0;
            next_osc = ~osc_core_clock;
        end
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            osc_cnt <= 4'h0;
            osc_core_clock <= 1'b0;
        end else begin
            osc_cnt <= next_osc_cnt;
            osc_core_clock <= next_osc;
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[`PCPS_ST_LOCK] = lock_indicator;
        status[`PCPS_ST_CFG_ERR] = cfg_err;
        status[`PCPS_ST_HELD] = held;
        status[`PCPS_ST_OSC_RUN] = ctrl.osc_enable;
        status[`PCPS_ST_PRODUCT +: 24] = product;
    end
endmodule

// file: verification/pcps_checker.sv
// checker for the pll control block top module
`timescale 1ns/1ps
`include "pcps_params.svh"
module pcps_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [3:0] ref_clock_inputs,
    input wire logic lock_indicator,
    input wire logic [3:0] global_clock_net,
    input wire logic pll_output_four_top,
    input wire logic pll_output_four_bottom,
    input wire logic osc_core_clock
);
    logic [31:0] ctl, fb, rte;
    logic [3:0] refq;
    logic [7:0] quiet, en;
    logic tk, bad;
    assign tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign bad = int'(fb[7:0]) * int'(fb[15:8]) * int'(fb[23:16]) > `PCPS_PRODUCT_MAX;
    // shadow copies of written registers, one cycle ahead of the design
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= `PCPS_RST_CTRL;
            fb <= `PCPS_RST_FBDIV;
            rte <= `PCPS_RST_ROUTE;
            refq <= 4'h0;
            quiet <= 8'h0;
            en <= 8'h0;
        end else begin
            ctl <= (tk && s_axi_awaddr == `PCPS_ADDR_CTRL) ? s_axi_wdata : ctl;
            fb <= (tk && s_axi_awaddr == `PCPS_ADDR_FBDIV) ? s_axi_wdata : fb;
            rte <= (tk && s_axi_awaddr == `PCPS_ADDR_ROUTE) ? s_axi_wdata : rte;
            refq <= ref_clock_inputs;
            quiet <= (refq != ref_clock_inputs) ? 8'h0 : quiet + {7'h0, quiet != 8'hFF};
            en <= (!ctl[0] || bad) ? 8'h0 : en + {7'h0, en != 8'hFF};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_held; !ctl[0] [*4] |-> !lock_indicator; endproperty
    a_held: assert property (p_held) else $error("lock high while pll held");
    property p_cfg; bad [*4] |-> !lock_indicator; endproperty
    a_cfg: assert property (p_cfg) else $error("lock high with bad divider product");
    property p_loss; quiet >= 8'h48 |-> !lock_indicator; endproperty
    a_loss: assert property (p_loss) else $error("lock kept with reference stopped");
    property p_early; $rose(lock_indicator) |-> en >= 8'h1E; endproperty
    a_early: assert property (p_early) else $error("lock rose too soon");
    property p_osc; !ctl[4] [*4] |-> !osc_core_clock; endproperty
    a_osc: assert property (p_osc) else $error("oscillator runs while disabled");
    property p_g0; !rte[0] [*4] |=> $stable(global_clock_net[0]); endproperty
    a_g0: assert property (p_g0) else $error("global output moves while unrouted");
    property p_top; !rte[4] [*4] |=> $stable(pll_output_four_top); endproperty
    a_top: assert property (p_top) else $error("top regional moves while unrouted");
    property p_bot; !rte[5] [*4] |=> $stable(pll_output_four_bottom); endproperty
    a_bot: assert property (p_bot) else $error("bottom regional moves while unrouted");
    c_lock: cover property ($rose(lock_indicator));
    c_cfg: cover property (bad && !lock_indicator);
    c_osc: cover property ($rose(osc_core_clock));
endmodule
bind pcps_top pcps_checker chk_i (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .ref_clock_inputs, .lock_indicator, .global_clock_net, .pll_output_four_top, .pll_output_four_bottom,
    .osc_core_clock
);

// file: verification/pcps_fabric.sv
// fabric-side model: reference clocks and feedback wiring
`timescale 1ns/1ps
module pcps_fabric (
    input wire logic run,
    input wire logic [1:0] sel,
    input wire logic pin_mode,
    output wire logic [3:0] ref_clock_inputs,
    output wire logic core_feedback_input,
    output wire logic pin_feedback_input
);
    wire logic [1:0] alt = sel + 2'h1;
    for (genvar i = 0; i < 4; i++) begin : g_ref
        logic t = 1'h0;
        // each reference at its own rate, standing still while stopped
        always #(60 + 10 * i) t = run ? ~t : t;
        assign ref_clock_inputs[i] = t;
    end
    // the unused feedback input carries a wrong clock
    assign core_feedback_input = pin_mode ? ref_clock_inputs[alt] : ref_clock_inputs[sel];
    assign pin_feedback_input = pin_mode ? ref_clock_inputs[sel] : ref_clock_inputs[alt];
endmodule

// file: verification/tb_top.sv
// self-checking bench for the pll control block
`timescale 1ns/1ps
`include "pcps_params.svh"
module tb_top;
    logic clk = 1'h0, rst_n = 1'h0, run = 1'h1, fpin = 1'h0;
    logic [1:0] fsel = 2'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] ref_clock_inputs, global_clock_net;
    logic core_feedback_input, pin_feedback_input, lock_indicator;
    logic pll_output_four_top, pll_output_four_bottom, osc_core_clock;
    logic [5:0] outs;
    int err_count = 0;
    int cmp_count = 0;
    logic [7:0] ra [6] = '{`PCPS_ADDR_CTRL, `PCPS_ADDR_PHASE, `PCPS_ADDR_FBDIV, `PCPS_ADDR_OUTDIV,
        `PCPS_ADDR_OUTDIV4, `PCPS_ADDR_ROUTE};
    logic [31:0] rv [6] = '{`PCPS_RST_CTRL, `PCPS_RST_PHASE, `PCPS_RST_FBDIV, `PCPS_RST_OUTDIV,
        `PCPS_RST_OUTDIV4, `PCPS_RST_ROUTE};
    logic [31:0] hp [4] = '{`PCPS_OSC_HALF_10, `PCPS_OSC_HALF_20, `PCPS_OSC_HALF_40, `PCPS_OSC_HALF_80};
    assign outs = {pll_output_four_bottom, pll_output_four_top, global_clock_net};
    always #12.5 clk = ~clk;
    pcps_top dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1),
        .ref_clock_inputs, .core_feedback_input, .pin_feedback_input, .lock_indicator, .global_clock_net,
        .pll_output_four_top, .pll_output_four_bottom, .osc_core_clock);
    pcps_fabric fab (.run, .sel(fsel), .pin_mode(fpin), .ref_clock_inputs, .core_feedback_input,
        .pin_feedback_input);
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic tmo();
        err_count++;
        $display("FAIL %0t wait timed out", $time);
        complete_run();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                chk(32'(s_axi_bresp), 32'(er));
                n = 99;
            end
        end
        if (n == 50) tmo();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                chk(s_axi_rdata & m, exp);
                chk(32'(s_axi_rresp), 32'(er));
                n = 99;
            end
        end
        if (n == 50) tmo();
    endtask
    task automatic wait_lock(input logic exp);
        int n = 0;
        while (lock_indicator !== exp && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) tmo();
    endtask
    task automatic watch(input int i, input logic exp);
        logic v, c;
        v = outs[i];
        c = 1'h0;
        repeat (40) begin
            @(posedge clk);
            c = c | (outs[i] !== v);
        end
        chk(32'(c), 32'(exp));
    endtask
    // cycles from an edge of output one to the next edge of output zero
    task automatic skew(input logic [31:0] exp);
        logic a, b;
        int n, t = -1;
        a = global_clock_net[0];
        b = global_clock_net[1];
        for (n = 0; n < 80; n++) begin
            @(posedge clk);
            if (t < 0 && global_clock_net[1] !== b) t = n;
            if (t >= 0 && global_clock_net[0] !== a) break;
            a = global_clock_net[0];
        end
        chk(32'(n - t), exp);
    endtask
    task automatic half_per(input logic [31:0] exp);
        logic v;
        int n = 0, t = 0;
        v = osc_core_clock;
        while (t < 2 && n < 40) begin
            @(posedge clk);
            n++;
            if (osc_core_clock !== v) begin
                t++;
                v = osc_core_clock;
                n = (t == 1) ? 0 : n;
            end
        end
        chk(32'(n), exp);
    endtask
    initial begin
        logic [2:0] s;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], rv[i], 32'hFFFF_FFFF, 2'h0);
        end
        rd(8'h1C, 32'h0, 32'hFFFF_FFFF, 2'h2);
        wr(8'h1C, 32'hFFFF_FFFF, 2'h2);
        wr(`PCPS_ADDR_OUTDIV, 32'h1010_1010, 2'h0);
        for (s = 3'h0; s < 3'h4; s++) begin
            wr(`PCPS_ADDR_CTRL, {28'h0, s[0], s[1:0], 1'h0}, 2'h0);
            fsel <= s[1:0];
            fpin <= s[0];
            repeat (20) @(posedge clk);
            wr(`PCPS_ADDR_CTRL, {28'h0, s[0], s[1:0], 1'h1}, 2'h0);
            wait_lock(1'h1);
            rd(`PCPS_ADDR_STATUS, 32'h0000_0101, 32'hFFFF_FFFF, 2'h0);
            watch(s, 1'h1);
        end
        wr(`PCPS_ADDR_CTRL, 32'h0000_008F, 2'h0);
        repeat (3) @(posedge clk);
        chk(32'(outs[0] ^ outs[1]), 32'h1);
        skew(32'h0);
        wr(`PCPS_ADDR_PHASE, 32'h0000_0007, 2'h0);
        repeat (40) @(posedge clk);
        wr(`PCPS_ADDR_PHASE, 32'h0000_010F, 2'h0);
        repeat (130) @(posedge clk);
        wr(`PCPS_ADDR_PHASE, 32'h0000_0007, 2'h0);
        repeat (130) @(posedge clk);
        skew(32'h7);
        for (int i = 0; i < 2; i++) begin
            wr(`PCPS_ADDR_ROUTE, 32'h10 << i, 2'h0);
            watch(4 + i, 1'h1);
            watch(5 - i, 1'h0);
            watch(0, 1'h0);
        end
        run <= 1'h0;
        wait_lock(1'h0);
        run <= 1'h1;
        wait_lock(1'h1);
        wr(`PCPS_ADDR_FBDIV, 32'h0101_1010, 2'h0);
        wait_lock(1'h0);
        rd(`PCPS_ADDR_STATUS, 32'h0001_0002, 32'hFFFF_FFF3, 2'h0);
        wr(`PCPS_ADDR_FBDIV, 32'h0101_01FF, 2'h0);
        rd(`PCPS_ADDR_STATUS, 32'h0000_FF00, 32'hFFFF_FF02, 2'h0);
        for (s = 3'h0; s < 3'h4; s++) begin
            wr(`PCPS_ADDR_CTRL, {25'h0, s[1:0], 5'h10}, 2'h0);
            repeat (20) @(posedge clk);
            half_per(hp[s[1:0]]);
        end
        wr(`PCPS_ADDR_CTRL, 32'h0, 2'h0);
        repeat (10) @(posedge clk);
        complete_run();
    end
endmodule
